// ---- sldc_damping_cfg.sv ----
// secondary loop damping / second phase detector gain register
// assumes the microprocessor port strobes are one-cycle and synchronous
//
// Behaviour
// - read/write register at 0x6a sets damping and detector gain
// - bits 6:4 set detector gain for refs at or below 8 kHz, analog
// - gain field used only when the auto gain selection input auto_gain_en is set
// - bits 2:0 select damping; default code 011, factor 5
// - damping codes give gain peaking from 0.4 dB down to 0.03 dB

`timescale 1ns/10ps
`default_nettype none

module sldc_damping_cfg (
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst_b,
    input  wire logic                     clk_en,
    // microprocessor port
    input  wire sldc_pkg::sldc_bus_t      bus,
    output logic                    [7:0] rdata_reg,
    // loop mode from elsewhere in the device
    input  wire logic                     auto_gain_en,
    input  wire logic                     low_rate_ref,
    input  wire logic                     analog_fb,
    // settings to the loop
    output var sldc_pkg::sldc_loop_cfg_t  loop_cfg_reg
);
    import sldc_pkg::*;

    logic [7:0]  secondary_loop_damping_cfg_reg;
    logic [7:0]  cfg_next;
    logic        hit;
    logic [2:0]  gain_sel;
    logic        gain_valid;
    logic [2:0]  damping_reg;

    ////////////////////////////////////////////////////////////////////////
    // register write
    assign hit = (bus.addr == SLDC_ADDR_DAMPING);
    assign cfg_next = bus.wdata & SLDC_WR_MASK;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            secondary_loop_damping_cfg_reg <= SLDC_RESET_DAMPING;
        end else if (clk_en && bus.wr && hit) begin
            secondary_loop_damping_cfg_reg <= cfg_next;
        end
    end

    // read data, unmapped reads as zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= '0;
        end else if (clk_en && bus.rd) begin
            rdata_reg <= hit ? secondary_loop_damping_cfg_reg : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gain qualification
    sldc_gain_sel #(
        .W (SLDC_GAIN_W)
    ) u_gain_sel (
        .mclk         (mclk),
        .rst_b        (rst_b),
        .clk_en       (clk_en),
        .auto_gain_en (auto_gain_en),
        .low_rate_ref (low_rate_ref),
        .analog_fb    (analog_fb),
        .field_gain   (secondary_loop_damping_cfg_reg[SLDC_GAIN_LSB +:
                                                      SLDC_GAIN_W]),
        .gain_reg     (gain_sel),
        .valid_reg    (gain_valid)
    );

    // damping code to the loop filter, which sets the peaking
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            damping_reg <= SLDC_DAMP_DEFAULT;
        end else if (clk_en) begin
            damping_reg <= secondary_loop_damping_cfg_reg[
                SLDC_DAMP_LSB +: SLDC_DAMP_W];
        end
    end

    // one driver for the whole carrier; every member is a flop
    assign loop_cfg_reg = '{
        damping       : damping_reg,
        pd_gain       : gain_sel,
        pd_gain_valid : gain_valid
    };

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_write_reads_back;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && bus.wr && hit) |=>
            secondary_loop_damping_cfg_reg == ($past(bus.wdata) & SLDC_WR_MASK);
    endproperty
    a_write_reads_back: assert property (p_write_reads_back)
        else $error("register write not stored");

    property p_unused_zero;
        @(posedge mclk) disable iff (!rst_b)
        secondary_loop_damping_cfg_reg[7] == 1'b0 &&
        secondary_loop_damping_cfg_reg[3] == 1'b0;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bits set");

    property p_gain_applied;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && auto_gain_en && low_rate_ref && analog_fb) |=>
            loop_cfg_reg.pd_gain_valid &&
            loop_cfg_reg.pd_gain == $past(secondary_loop_damping_cfg_reg[6:4]);
    endproperty
    a_gain_applied: assert property (p_gain_applied)
        else $error("detector gain not applied");

    property p_gain_ignored;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && !auto_gain_en) |=> !loop_cfg_reg.pd_gain_valid;
    endproperty
    a_gain_ignored: assert property (p_gain_ignored)
        else $error("gain field used without auto selection");

    property p_damping_follows;
        @(posedge mclk) disable iff (!rst_b)
        clk_en |=> loop_cfg_reg.damping ==
            $past(secondary_loop_damping_cfg_reg[2:0]);
    endproperty
    a_damping_follows: assert property (p_damping_follows)
        else $error("damping code not forwarded");

    // read of the register returns its stored value
    property p_read_returns;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && bus.rd && hit) |=>
            rdata_reg == $past(secondary_loop_damping_cfg_reg);
    endproperty
    a_read_returns: assert property (p_read_returns)
        else $error("read data differs from register");

    // read of any other address returns zero
    property p_read_other_zero;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && bus.rd && !hit) |=> rdata_reg == 8'h00;
    endproperty
    a_read_other_zero: assert property (p_read_other_zero)
        else $error("unmapped read not zero");

    // write to another address leaves the register alone
    property p_other_write;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && bus.wr && !hit) |=>
            $stable(secondary_loop_damping_cfg_reg);
    endproperty
    a_other_write: assert property (p_other_write)
        else $error("register changed by foreign write");

    // read data stands until the next read
    property p_rdata_holds;
        @(posedge mclk) disable iff (!rst_b)
        !(clk_en && bus.rd) |=> $stable(rdata_reg);
    endproperty
    a_rdata_holds: assert property (p_rdata_holds)
        else $error("read data changed without read");

    // clock enable low freezes every piece of state
    property p_freeze;
        @(posedge mclk) disable iff (!rst_b)
        !clk_en |=> $stable(secondary_loop_damping_cfg_reg) &&
            $stable(rdata_reg) && $stable(loop_cfg_reg);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved with clock enable low");

    // gain field unused for references above the low rate
    property p_low_rate_only;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && !low_rate_ref) |=> !loop_cfg_reg.pd_gain_valid;
    endproperty
    a_low_rate_only: assert property (p_low_rate_only)
        else $error("gain applied above low rate");

    // gain field unused outside analog feedback
    property p_analog_only;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && !analog_fb) |=> !loop_cfg_reg.pd_gain_valid;
    endproperty
    a_analog_only: assert property (p_analog_only)
        else $error("gain applied outside analog feedback");

    // ignored field must not reach the detector gain
    property p_gain_held;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && !(auto_gain_en && low_rate_ref && analog_fb)) |=>
            $stable(loop_cfg_reg.pd_gain);
    endproperty
    a_gain_held: assert property (p_gain_held)
        else $error("detector gain moved while ignored");

    // reset puts the register and outputs at their defaults
    property p_reset_values;
        @(posedge mclk)
        !rst_b |-> secondary_loop_damping_cfg_reg == SLDC_RESET_DAMPING &&
            rdata_reg == 8'h00 && !loop_cfg_reg.pd_gain_valid;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("reset values wrong");

    // reset damping code is the default one
    property p_damping_reset;
        @(posedge mclk)
        !rst_b |-> loop_cfg_reg.damping == SLDC_DAMP_DEFAULT;
    endproperty
    a_damping_reset: assert property (p_damping_reset)
        else $error("reset damping code wrong");

    // unused bits always read back as zero
    property p_read_unused_zero;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && bus.rd) |=> !rdata_reg[7] && !rdata_reg[3];
    endproperty
    a_read_unused_zero: assert property (p_read_unused_zero)
        else $error("unused bits read as one");

endmodule // sldc_damping_cfg

`default_nettype wire

// ---- sldc_pkg.sv ----
// package for the secondary loop damping / detector gain register
// assumes an 8-bit microprocessor port with byte addresses

package sldc_pkg;

    // register map
    localparam logic [7:0] SLDC_ADDR_DAMPING  = 8'h6a;
    localparam logic [7:0] SLDC_RESET_DAMPING = 8'h13;

    // field positions
    localparam int SLDC_GAIN_LSB  = 4;
    localparam int SLDC_GAIN_W    = 3;
    localparam int SLDC_DAMP_LSB  = 0;
    localparam int SLDC_DAMP_W    = 3;
    localparam int SLDC_AUTO_BIT  = 7;

    // writable bits: 6:4 and 2:0; 7 and 3 read zero
    localparam logic [7:0] SLDC_WR_MASK = 8'h77;

    // damping codes
    localparam logic [2:0] SLDC_DAMP_UNUSED0 = 3'h0;
    localparam logic [2:0] SLDC_DAMP_DEFAULT = 3'h3;
    localparam logic [2:0] SLDC_DAMP_MAX     = 3'h5;

    // register access carrier
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sldc_bus_t;

    // loop settings to the loop filter
    typedef struct packed {
        logic [2:0] damping;
        logic [2:0] pd_gain;
        logic       pd_gain_valid;
    } sldc_loop_cfg_t;

endpackage : sldc_pkg

// ---- sldc_gain_sel.sv ----
// selects the second phase detector gain for the low-rate analog case
// assumes mode inputs synchronous to mclk

`timescale 1ns/10ps
`default_nettype none

module sldc_gain_sel #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    // selection inputs
    input  wire logic         auto_gain_en,
    input  wire logic         low_rate_ref,
    input  wire logic         analog_fb,
    input  wire logic [W-1:0] field_gain,
    // registered result
    output logic      [W-1:0] gain_reg,
    output logic              valid_reg
);

    // field applies only with auto gain, low rate, analog feedback
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gain_reg  <= '0;
            valid_reg <= 1'b0;
        end else if (clk_en) begin
            valid_reg <= auto_gain_en & low_rate_ref & analog_fb;
            if (auto_gain_en & low_rate_ref & analog_fb) begin
                gain_reg <= field_gain;
            end
        end
    end

endmodule // sldc_gain_sel

`default_nettype wire

// ---- sldc_damping_cfg_tb.sv ----
// testbench for the damping / detector gain register
// assumes sldc_pkg and sldc_damping_cfg are compiled first
`timescale 1ns/10ps
`default_nettype none

module dpll_damping_gain_config_tb_top;
    import sldc_pkg::*;
    logic           mclk = 0;
    logic           rst_b = 1;
    logic           clk_en = 1;
    sldc_bus_t      bus = '0;
    logic     [7:0] rdata_reg;
    logic     [2:0] mode = 3'h0;
    sldc_loop_cfg_t loop_cfg_reg;
    int             mismatches = 0;
    int             checks = 0;
    // rows: wdata, mode {auto,low,analog}, readback, gain valid
    logic    [19:0] rows [6] = '{
        {8'h55, 3'h7, 8'h55, 1'h1}, {8'hff, 3'h7, 8'h77, 1'h1},
        {8'h00, 3'h7, 8'h00, 1'h1}, {8'h23, 3'h5, 8'h23, 1'h0},
        {8'h64, 3'h6, 8'h64, 1'h0}, {8'h41, 3'h3, 8'h41, 1'h0}};
    // clock
    always #5 mclk = ~mclk;
    sldc_damping_cfg u_dut (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
        .bus(bus), .rdata_reg(rdata_reg), .auto_gain_en(mode[2]),
        .low_rate_ref(mode[1]), .analog_fb(mode[0]),
        .loop_cfg_reg(loop_cfg_reg));
    ////////////////////////////////////////////////////////////////////////
    // compare and report
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task test_done();
        if (mismatches == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one-cycle strobes on the microprocessor port
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) bus <= '{rd: 1'h0, wr: 1'h1, addr: a, wdata: d};
        @(posedge mclk) bus <= '0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge mclk) bus <= '{rd: 1'h1, wr: 1'h0, addr: a, wdata: 8'h00};
        @(posedge mclk) bus <= '0;
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_b <= 1'h0;
        repeat (5) @(posedge mclk);
        rst_b <= 1'h1;
        #1;
        chk({5'h00, loop_cfg_reg.damping}, 8'h03);
        chk({7'h00, loop_cfg_reg.pd_gain_valid}, 8'h00);
        rd(SLDC_ADDR_DAMPING);
        chk(rdata_reg, SLDC_RESET_DAMPING);
        foreach (rows[i]) begin
            @(posedge mclk) mode <= rows[i][11:9];
            wr(SLDC_ADDR_DAMPING, rows[i][19:12]);
            rd(SLDC_ADDR_DAMPING);
            chk(rdata_reg, rows[i][8:1]);
            chk({5'h00, loop_cfg_reg.damping}, {5'h00, rows[i][3:1]});
            chk({7'h00, loop_cfg_reg.pd_gain_valid},
                {7'h00, rows[i][0]});
            if (rows[i][0])
                chk({5'h00, loop_cfg_reg.pd_gain},
                    {5'h00, rows[i][7:5]});
        end
        // other address neither written nor read back
        wr(8'h6b, 8'h00);
        rd(SLDC_ADDR_DAMPING);
        chk(rdata_reg, 8'h41);
        rd(8'h6b);
        chk(rdata_reg, 8'h00);
        // clock enable low freezes the register
        @(posedge mclk) clk_en <= 1'h0;
        wr(SLDC_ADDR_DAMPING, 8'h12);
        @(posedge mclk) clk_en <= 1'h1;
        rd(SLDC_ADDR_DAMPING);
        chk(rdata_reg, 8'h41);
        // second reset in mid-run restores the default
        @(posedge mclk) rst_b <= 1'h0;
        @(posedge mclk) rst_b <= 1'h1;
        rd(SLDC_ADDR_DAMPING);
        chk(rdata_reg, SLDC_RESET_DAMPING);
        chk({5'h00, loop_cfg_reg.damping}, 8'h03);
        test_done();
    end
endmodule // dpll_damping_gain_config_tb_top

`default_nettype wire
